// *** ext_irq_and_priority_config_test.sv ***
// self-checking bench for the priority byte and external interrupt inputs
// assumes ext_irq_top and the source model; Avalon-MM master in the bench
`timescale 1ns/1ns
`default_nettype none
module ext_irq_and_priority_config_test;
    import ext_irq_pkg::*;

    localparam logic [4:0] tc_addr = 5'h08;

    logic       clk;
    logic       rst_b;
    avm_req_t   bus_req;
    avm_resp_t  bus_resp;
    logic [7:0] port_pins;
    logic [1:0] vector_ack;
    logic [1:0] ext_irq_pending;
    prio_bits_t prio_levels;
    logic       irq;
    logic       seen;
    int         fail_count;
    int         check_count;

    ext_irq_top dut (.clk(clk), .rst_b(rst_b), .bus_req(bus_req), .bus_resp(bus_resp),
        .port_pins(port_pins), .vector_ack(vector_ack),
        .ext_irq_pending(ext_irq_pending), .prio_levels(prio_levels), .irq(irq));

    ext_src_model src (.clk(clk), .pending(ext_irq_pending), .port_pins(port_pins));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        int n;
        @(posedge clk);
        bus_req <= '{read: !wr, write: wr, address: a, writedata: {24'h0, d},
                     byteenable: 4'hF};
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (bus_resp.waitrequest !== 1'b0 && n < 20);
        if (bus_resp.waitrequest !== 1'b0)
        begin
            fail_count++;
            complete_run();
        end
        else
        begin
            q = bus_resp.readdata[7:0];
            bus_req <= '0;
        end
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(q, exp);
    endtask : rdchk

    task automatic pulse_ack(input logic [1:0] which);
        @(posedge clk);
        vector_ack <= which;
        @(posedge clk);
        vector_ack <= 2'h0;
    endtask : pulse_ack

    task automatic wait_pend(input int idx, input logic v);
        int n;
        for (n = 0; n < 8 && ext_irq_pending[idx] !== v; n++)
            @(posedge clk);
        chk(ext_irq_pending[idx], v);
        if (ext_irq_pending[idx] !== v)
            complete_run();
    endtask : wait_pend

    task automatic sc_regs;
        rdchk(5'h00, 8'hC0);
        chk(prio_levels, 6'h00);
        rdchk(5'h04, 8'h00);
        rdchk(tc_addr, 8'h0A);
        rdchk(5'h10, 8'h00);
        for (int i = 0; i < 6; i++)
        begin
            wr(5'h00, 8'h01 << i);
            rdchk(5'h00, 8'hC0 | (8'h01 << i));
            chk(prio_levels, 6'h01 << i);
        end
        wr(5'h00, 8'h00);
        rdchk(5'h00, 8'hC0);
        wr(5'h14, 8'h3F);
        rdchk(5'h14, 8'h00);
        rdchk(5'h00, 8'hC0);
    endtask : sc_regs

    task automatic sc_modes;
        logic pol;
        logic trig;
        for (int m = 0; m < 4; m++)
        begin
            pol = m[0];
            trig = m[1];
            src.drive_pin(3, !pol);
            wr(5'h04, {4'h0, pol, 3'h3});
            wr(tc_addr, {7'h0, trig});
            pulse_ack(2'b01);
            repeat (4) @(posedge clk);
            chk(ext_irq_pending[0], 1'b0);
            src.drive_pin(3, pol);
            wait_pend(0, 1'b1);
            rdchk(tc_addr, {4'h0, 1'b1, 1'b0, 1'b1, trig});
            src.drive_pin(3, !pol);
            repeat (4) @(posedge clk);
            chk(ext_irq_pending[0], trig);
            pulse_ack(2'b01);
            repeat (2) @(posedge clk);
            chk(ext_irq_pending[0], 1'b0);
        end
    endtask : sc_modes

    task automatic sc_irq;
        src.drive_pin(6, 1'b0);
        src.drive_pin(7, 1'b0);
        wr(5'h04, 8'hE8);
        wr(tc_addr, 8'h04);
        pulse_ack(2'b10);
        wr(5'h0C, 8'h03);
        wr(5'h10, 8'h02);
        src.drive_pin(7, 1'b1);
        repeat (5) @(posedge clk);
        chk(ext_irq_pending[1], 1'b0);
        chk(irq, 1'b0);
        src.drive_pin(6, 1'b1);
        wait_pend(1, 1'b1);
        repeat (2) @(posedge clk);
        chk(irq, 1'b1);
        rdchk(5'h0C, 8'h02);
        rdchk(tc_addr, 8'h0C);
        wr(5'h10, 8'h00);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        wr(5'h10, 8'h02);
        repeat (2) @(posedge clk);
        chk(irq, 1'b1);
        pulse_ack(2'b10);
        repeat (2) @(posedge clk);
        chk(ext_irq_pending[1], 1'b0);
        wr(5'h0C, 8'h02);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        rdchk(5'h0C, 8'h00);
    endtask : sc_irq

    task automatic sc_level_src;
        src.drive_pin(5, 1'b1);
        wr(5'h04, 8'h58);
        wr(tc_addr, 8'h00);
        repeat (4) @(posedge clk);
        chk(ext_irq_pending[1], 1'b0);
        src.level_req(5, 1'b0, 1, seen);
        chk(seen, 1'b1);
        repeat (4) @(posedge clk);
        chk(ext_irq_pending[1], 1'b0);
    endtask : sc_level_src

    initial
    begin
        fail_count = 0;
        check_count = 0;
        rst_b = 1'b0;
        bus_req = '0;
        vector_ack = 2'h0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (5) @(posedge clk);
        sc_regs();
        sc_modes();
        sc_irq();
        sc_level_src();
        complete_run();
    end
endmodule : ext_irq_and_priority_config_test
`default_nettype wire

// *** ext_irq_detect.sv ***
// one external interrupt input: polarity, edge or level detect, pending flag
// assumes pin_level is already synchronised to clk
`timescale 1ns/1ns
`default_nettype none
module ext_irq_detect
    import ext_irq_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pin_level,
    input  wire logic polarity,
    input  wire logic edge_mode,
    input  wire logic vector_ack,
    input  wire logic sw_wr,
    input  wire logic sw_val,
    output logic      pending,
    output logic      set_event
);

    typedef struct packed {
        logic prev_active;
        logic pending;
        logic set_event;
    } det_state_t;

    det_state_t r;
    det_state_t r_nxt;
    logic       active;
    logic       rise;

    always_comb
    begin
        active = polarity ? pin_level : ~pin_level;
        rise   = active & ~r.prev_active;
        r_nxt  = r;
        r_nxt.prev_active = active;
        if (edge_mode)
        begin
            if (sw_wr)
                r_nxt.pending = sw_val;
            if (vector_ack)
                r_nxt.pending = 1'b0;
            if (rise)
                r_nxt.pending = 1'b1;
        end
        else
            r_nxt.pending = active;
        r_nxt.set_event = r_nxt.pending & ~r.pending;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            r <= '0;
        else
            r <= r_nxt;
    end

    assign pending   = r.pending;
    assign set_event = r.set_event;

    a_level_follow: assert property (@(posedge clk) disable iff (!rst_n)
        !edge_mode |=> pending == $past(polarity ? pin_level : ~pin_level))
        else $error("level mode pending does not follow input");
    a_edge_set: assert property (@(posedge clk) disable iff (!rst_n)
        edge_mode && active && !r.prev_active |=> pending)
        else $error("active edge did not set pending");
    a_ack_clear: assert property (@(posedge clk) disable iff (!rst_n)
        edge_mode && vector_ack && !rise |=> !pending)
        else $error("vectoring did not clear pending");
    a_edge_hold: assert property (@(posedge clk) disable iff (!rst_n)
        edge_mode && pending && !vector_ack && !sw_wr |=> pending)
        else $error("edge pending dropped without clear");

endmodule : ext_irq_detect
`default_nettype wire

// *** ext_irq_pkg.sv ***
// constants, field layouts and bus carriers for the external interrupt block
// assumes a single 25 MHz clock and an Avalon-MM master with waitrequest
// Behaviour
// - bit 5 of second priority register: comparator rising edge, 1 high
// - bit 4 of second priority register: comparator falling edge, 1 high
// - bit 3 of second priority register: counter array, 1 high
// - bit 2 of second priority register: converter complete, 1 high
// - bit 1 of second priority register: converter window compare, 1 high
// - per-input polarity bit in config register: 0 active low, 1 high
// - per-input trigger bit in timer control: 1 edge, 0 level
// - config register picks monitored pin; monitoring never drives the pin
// - pending flags for inputs a and b sit at timer control bits 1, 3
// - edge mode: active edge sets pending, CPU vectoring clears it
// - level mode: pending reads 1 while input active, 0 while inactive
package ext_irq_pkg;

    localparam int          ADDR_W         = 5;
    localparam logic [4:0]  OFF_PRIO       = 5'h00;
    localparam logic [4:0]  OFF_CFG        = 5'h04;
    localparam logic [4:0]  OFF_TIMER_CONTROL_REG       = 5'h08;
    localparam logic [4:0]  OFF_STAT       = 5'h0C;
    localparam logic [4:0]  OFF_MASK       = 5'h10;

    localparam logic [7:0]  PRIO_RESET     = 8'hC0;
    localparam logic [7:0]  PRIO_UNUSED    = 8'hC0;
    localparam logic [7:0]  CFG_RESET      = 8'h00;
    localparam logic [1:0]  TRIG_RESET     = 2'h0;
    localparam logic [1:0]  STAT_RESET     = 2'h0;
    localparam logic [1:0]  MASK_RESET     = 2'h0;

    localparam int          PRIO_CMP_RISE  = 5;
    localparam int          PRIO_CMP_FALL  = 4;
    localparam int          PRIO_CNT_ARRAY = 3;
    localparam int          PRIO_CONV_DONE = 2;
    localparam int          PRIO_CONV_WIN  = 1;
    localparam int          PRIO_TWOWIRE   = 0;

    localparam int          CFG_B_POL      = 7;
    localparam int          CFG_B_SEL      = 4;
    localparam int          CFG_A_POL      = 3;
    localparam int          CFG_A_SEL      = 0;

    localparam int          TIMER_CONTROL_REG_A_TRIG    = 0;
    localparam int          TIMER_CONTROL_REG_A_PEND    = 1;
    localparam int          TIMER_CONTROL_REG_B_TRIG    = 2;
    localparam int          TIMER_CONTROL_REG_B_PEND    = 3;

    localparam int          STAT_EVT_A     = 0;
    localparam int          STAT_EVT_B     = 1;

    typedef struct packed {
        logic cmp_rise_priority;
        logic cmp_fall_priority;
        logic counter_array_priority;
        logic conv_done_priority;
        logic conv_window_priority;
        logic twowire_priority;
    } prio_bits_t;

    typedef struct packed {
        logic              read;
        logic              write;
        logic [ADDR_W-1:0] address;
        logic [31:0]       writedata;
        logic [3:0]        byteenable;
    } avm_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } avm_resp_t;

endpackage : ext_irq_pkg

// *** ext_irq_top.sv ***
// register file, pin selection and interrupt status for both external inputs
// assumes Avalon-MM master on clk; port pins asynchronous to clk
//
// Chosen here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module ext_irq_top
    import ext_irq_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire avm_req_t   bus_req,
    output avm_resp_t       bus_resp,
    input  wire logic [7:0] port_pins,
    input  wire logic [1:0] vector_ack,
    output logic [1:0]      ext_irq_pending,
    output prio_bits_t      prio_levels,
    output logic            irq
);

    typedef struct packed {
        logic [7:0] pin_meta;
        logic [7:0] pin_sync;
        prio_bits_t prio;
        logic [7:0] cfg;
        logic [1:0] trig;
        logic [1:0] stat;
        logic [1:0] mask;
        logic       irq;
        logic [31:0] readdata;
        logic       waitreq;
    } top_state_t;

    logic [1:0] rst_sync_r;
    logic       rst_n;
    top_state_t r;
    top_state_t r_nxt;
    logic       wr_take;
    logic       rd_take;
    logic       req_new;
    logic [1:0] lvl;
    logic [1:0] pend;
    logic [1:0] evt;
    logic [1:0] sw_wr;
    logic [7:0] wbyte;

    function automatic logic pick_pin(input logic [7:0] pins, input logic [2:0] sel);
        pick_pin = pins[sel];
    endfunction : pick_pin

    function automatic logic [7:0] prio_byte(input prio_bits_t p);
        prio_byte = PRIO_UNUSED | {2'h0, p};
    endfunction : prio_byte

    // reset release
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rst_sync_r <= 2'h0;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    assign wr_take = bus_req.write & ~r.waitreq;
    assign rd_take = bus_req.read & ~r.waitreq;
    assign req_new = (bus_req.read | bus_req.write) & r.waitreq;
    assign wbyte   = bus_req.writedata[7:0];

    // pins are only sampled, never driven
    assign lvl = {pick_pin(r.pin_sync, r.cfg[CFG_B_SEL +: 3]),
                  pick_pin(r.pin_sync, r.cfg[CFG_A_SEL +: 3])};

    assign sw_wr = {2{wr_take && bus_req.address == OFF_TIMER_CONTROL_REG && bus_req.byteenable[0]}};

    ext_irq_detect u_det_a (
        .clk        (clk),
        .rst_n      (rst_n),
        .pin_level  (lvl[0]),
        .polarity   (r.cfg[CFG_A_POL]),
        .edge_mode  (r.trig[0]),
        .vector_ack (vector_ack[0]),
        .sw_wr      (sw_wr[0]),
        .sw_val     (wbyte[TIMER_CONTROL_REG_A_PEND]),
        .pending    (pend[0]),
        .set_event  (evt[0])
    );

    ext_irq_detect u_det_b (
        .clk        (clk),
        .rst_n      (rst_n),
        .pin_level  (lvl[1]),
        .polarity   (r.cfg[CFG_B_POL]),
        .edge_mode  (r.trig[1]),
        .vector_ack (vector_ack[1]),
        .sw_wr      (sw_wr[1]),
        .sw_val     (wbyte[TIMER_CONTROL_REG_B_PEND]),
        .pending    (pend[1]),
        .set_event  (evt[1])
    );

    always_comb
    begin
        r_nxt          = r;
        r_nxt.pin_meta = port_pins;
        r_nxt.pin_sync = r.pin_meta;
        r_nxt.waitreq  = ~req_new;

        if (wr_take && bus_req.byteenable[0])
        begin
            case (bus_req.address)
                OFF_PRIO:
                begin
                    r_nxt.prio.cmp_rise_priority      = wbyte[PRIO_CMP_RISE];
                    r_nxt.prio.cmp_fall_priority      = wbyte[PRIO_CMP_FALL];
                    r_nxt.prio.counter_array_priority = wbyte[PRIO_CNT_ARRAY];
                    r_nxt.prio.conv_done_priority     = wbyte[PRIO_CONV_DONE];
                    r_nxt.prio.conv_window_priority   = wbyte[PRIO_CONV_WIN];
                    r_nxt.prio.twowire_priority       = wbyte[PRIO_TWOWIRE];
                end
                OFF_CFG:
                    r_nxt.cfg = wbyte;
                OFF_TIMER_CONTROL_REG:
                begin
                    r_nxt.trig[0] = wbyte[TIMER_CONTROL_REG_A_TRIG];
                    r_nxt.trig[1] = wbyte[TIMER_CONTROL_REG_B_TRIG];
                end
                OFF_STAT:
                    r_nxt.stat = r.stat & ~wbyte[1:0];
                OFF_MASK:
                    r_nxt.mask = wbyte[1:0];
                default:
                    r_nxt.stat = r.stat;
            endcase
        end
        // new events win over a clear in the same cycle
        r_nxt.stat[STAT_EVT_A] = r_nxt.stat[STAT_EVT_A] | evt[0];
        r_nxt.stat[STAT_EVT_B] = r_nxt.stat[STAT_EVT_B] | evt[1];
        r_nxt.irq = |(r_nxt.stat & r_nxt.mask);

        if (req_new && bus_req.read)
        begin
            case (bus_req.address)
                OFF_PRIO:
                    r_nxt.readdata = {24'h0, prio_byte(r.prio)};
                OFF_CFG:
                    r_nxt.readdata = {24'h0, r.cfg};
                OFF_TIMER_CONTROL_REG:
                    r_nxt.readdata = {28'h0, pend[1], r.trig[1], pend[0], r.trig[0]};
                OFF_STAT:
                    r_nxt.readdata = {30'h0, r.stat};
                OFF_MASK:
                    r_nxt.readdata = {30'h0, r.mask};
                default:
                    r_nxt.readdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r          <= '0;
            r.prio     <= prio_bits_t'(PRIO_RESET[5:0]);
            r.cfg      <= CFG_RESET;
            r.trig     <= TRIG_RESET;
            r.stat     <= STAT_RESET;
            r.mask     <= MASK_RESET;
            r.waitreq  <= 1'b1;
        end
        else
            r <= r_nxt;
    end

    assign bus_resp             = '{readdata: r.readdata, waitrequest: r.waitreq};
    assign ext_irq_pending      = pend;
    assign prio_levels          = r.prio;
    assign irq                  = r.irq;

    logic prio_wr;
    assign prio_wr = wr_take && bus_req.address == OFF_PRIO && bus_req.byteenable[0];

    a_prio_cmp_rise: assert property (@(posedge clk) disable iff (!rst_n)
        prio_wr |=> prio_levels.cmp_rise_priority == $past(bus_req.writedata[5]))
        else $error("comparator rise priority not written");
    a_prio_cmp_fall: assert property (@(posedge clk) disable iff (!rst_n)
        prio_wr |=> prio_levels.cmp_fall_priority == $past(bus_req.writedata[4]))
        else $error("comparator fall priority not written");
    a_prio_counter: assert property (@(posedge clk) disable iff (!rst_n)
        prio_wr |=> prio_levels.counter_array_priority == $past(bus_req.writedata[3]))
        else $error("counter array priority not written");
    a_prio_conv_done: assert property (@(posedge clk) disable iff (!rst_n)
        prio_wr |=> prio_levels.conv_done_priority == $past(bus_req.writedata[2]))
        else $error("converter done priority not written");
    a_prio_conv_win: assert property (@(posedge clk) disable iff (!rst_n)
        prio_wr |=> prio_levels.conv_window_priority == $past(bus_req.writedata[1]))
        else $error("converter window priority not written");
    a_prio_twowire: assert property (@(posedge clk) disable iff (!rst_n)
        prio_wr |=> prio_levels.twowire_priority == $past(bus_req.writedata[0]))
        else $error("two-wire priority not written");
    a_prio_upper_ones: assert property (@(posedge clk) disable iff (!rst_n)
        rd_take && bus_req.address == OFF_PRIO |-> bus_resp.readdata[7:6] == 2'h3)
        else $error("unused priority bits not read as ones");
    a_pin_select: assert property (@(posedge clk) disable iff (!rst_n)
        $stable(r.cfg) && r.cfg == $past(r.cfg, 2)
            |-> lvl[0] == $past(port_pins[r.cfg[2:0]], 2))
        else $error("monitored pin does not match selection");
    a_pend_bits: assert property (@(posedge clk) disable iff (!rst_n)
        rd_take && bus_req.address == OFF_TIMER_CONTROL_REG
            |-> bus_resp.readdata[3] == $past(pend[1])
                && bus_resp.readdata[1] == $past(pend[0]))
        else $error("pending flags misplaced in timer control");
    a_wait_answer: assert property (@(posedge clk) disable iff (!rst_n)
        req_new |=> !bus_resp.waitrequest ##1 bus_resp.waitrequest)
        else $error("bus answer not one cycle after request");

    c_edge_pend: cover property (@(posedge clk) disable iff (!rst_n)
        r.trig[0] && evt[0] ##[1:20] vector_ack[0]);
    c_level_pend: cover property (@(posedge clk) disable iff (!rst_n)
        !r.trig[1] && pend[1] ##[1:20] !pend[1]);
    c_irq_high: cover property (@(posedge clk) disable iff (!rst_n) irq);
    c_prio_write: cover property (@(posedge clk) disable iff (!rst_n) prio_wr);

endmodule : ext_irq_top
`default_nettype wire

// *** ext_src_model.sv ***
// external interrupt sources standing on the port pins
// assumes the bench calls its tasks hierarchically, one clock domain
`timescale 1ns/1ns
`default_nettype none
module ext_src_model
(
    input  wire logic       clk,
    input  wire logic [1:0] pending,
    output var  logic [7:0] port_pins
);
    // pins dedicated to the inputs, no other driver
    initial port_pins = 8'h00;

    task automatic drive_pin(input int idx, input logic v);
        @(posedge clk);
        port_pins[idx] <= v;
    endtask : drive_pin

    // level request held until recognised or for at most 16 clocks, then dropped one clock later
    task automatic level_req(input int idx, input logic act, input int which,
                             output logic seen);
        int n;
        seen = 1'b0;
        drive_pin(idx, act);
        for (n = 0; n < 16 && !seen; n++)
        begin
            @(posedge clk);
            seen = (pending[which] === 1'b1);
        end
        drive_pin(idx, !act);
    endtask : level_req
endmodule : ext_src_model
`default_nettype wire
